//--- afc_pkg.sv
// Package with register map, field layout and timing constants of the flow controller
package afc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  FLOW_CFG_OFFSET = 8'hac;
   localparam logic [7:0]  AFC_CTRL_OFFSET = 8'hb4;
   localparam logic [7:0]  AFC_STAT_OFFSET = 8'hb8;
   localparam logic [31:0] FLOW_CFG_RESET  = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int HI_MSB   = 23;
   localparam int HI_LSB   = 16;
   localparam int LO_MSB   = 15;
   localparam int LO_LSB   = 8;
   localparam int DUR_MSB  = 7;
   localparam int DUR_LSB  = 4;
   localparam int MULT_BIT = 3;
   localparam int BRD_BIT  = 2;
   localparam int ADD_BIT  = 1;
   localparam int ANY_BIT  = 0;
   localparam int CTRL_PAUSE_BIT = 0;
   localparam int CTRL_JAM_BIT   = 1;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ        = 250;
   localparam int UNIT_BYTES     = 64;
   localparam int UNIT_SHIFT     = 6;
   localparam int EXTRA_10M_NS   = 2200;
   localparam int EXTRA_10M_CYC  = (EXTRA_10M_NS * CLK_MHZ) / 1000;
   localparam int US_CYC         = CLK_MHZ;

   // Jam duration in microseconds, per select code, at 100 Mb/s
   function automatic int afc_dur_us(input logic [3:0] code);
      int r;
      r = 0;
      case (code)
         4'h0: r = 5;
         4'h1: r = 10;
         4'h2: r = 15;
         4'h3: r = 25;
         default: r = 50 * (int'(code) - 3);
      endcase
      return r;
   endfunction

   typedef enum logic [1:0] {
      AFC_IDLE = 2'b00,
      AFC_HIGH = 2'b01,
      AFC_WAIT = 2'b11
   } afc_state_t;

endpackage

//--- afc_apb_regs.sv
// APB slave holding the flow control configuration and software trigger bits
`timescale 1ns/1ps
module afc_apb_regs
   import afc_pkg::*;
(
   input  wire logic        mclk,         // System clock
   input  wire logic        rst,          // Async reset, active high
   input  wire logic        psel,         // APB select
   input  wire logic        penable,      // APB enable
   input  wire logic        pwrite,       // APB direction
   input  wire logic [7:0]  paddr,        // APB byte address
   input  wire logic [31:0] pwdata,       // APB write data
   output logic      [31:0] prdata,       // APB read data
   output logic             pready,       // APB ready
   output logic             pslverr,      // APB error
   input  wire logic [31:0] status_word,  // Block status for reading
   output logic      [23:0] cfg,          // Config fields
   output logic             sw_pause,     // Software pause request pulse
   output logic             sw_jam        // Software jam request pulse
);
   logic [23:0] cfg_q, cfg_d;
   logic [31:0] rdata_q, rdata_d;
   logic        err_q, err_d, swp_q, swp_d, swj_q, swj_d;
   logic        acc;

   assign acc = psel && penable;

   // --------------------------------------------------------------
   // Decode and next values
   // --------------------------------------------------------------
   always_comb
   begin
      cfg_d   = cfg_q;
      rdata_d = 32'h0000_0000;
      err_d   = 1'b0;
      swp_d   = 1'b0;
      swj_d   = 1'b0;
      if (psel && !penable)
      begin
         if (paddr == FLOW_CFG_OFFSET)
            rdata_d = {8'h00, cfg_q};
         else if (paddr == AFC_STAT_OFFSET)
            rdata_d = status_word;
         else if (paddr != AFC_CTRL_OFFSET)
            err_d = 1'b1;
      end
      // Writes land only at the edge that completes the access
      if (acc && pwrite)
      begin
         if (paddr == FLOW_CFG_OFFSET)
            cfg_d = pwdata[23:0];
         else if (paddr == AFC_CTRL_OFFSET)
         begin
            swp_d = pwdata[CTRL_PAUSE_BIT];
            swj_d = pwdata[CTRL_JAM_BIT];
         end
      end
   end

   // Captured in setup, so the access phase ends in one cycle
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cfg_q   <= FLOW_CFG_RESET[23:0];
         rdata_q <= 32'h0000_0000;
         err_q   <= 1'b0;
         swp_q   <= 1'b0;
         swj_q   <= 1'b0;
      end
      else
      begin
         cfg_q   <= cfg_d;
         rdata_q <= rdata_d;
         err_q   <= err_d;
         swp_q   <= swp_d;
         swj_q   <= swj_d;
      end
   end

   assign pready   = 1'b1;
   assign prdata   = acc ? rdata_q : 32'h0000_0000;
   assign pslverr  = acc && err_q;
   assign cfg      = cfg_q;
   assign sw_pause = swp_q;
   assign sw_jam   = swj_q;
endmodule

//--- afc_jam_timer.sv
// Countdown timer that holds back pressure for the selected duration
`timescale 1ns/1ps
module afc_jam_timer
   import afc_pkg::*;
#(
   parameter int CW = 18                     // Counter width
)
(
   input  wire logic       mclk,             // System clock
   input  wire logic       rst,              // Async reset, active high
   input  wire logic       start,            // Start pulse
   input  wire logic       abort,            // Stop at once
   input  wire logic [3:0] dur_sel,          // Duration select code
   input  wire logic       speed_10m,        // Link runs at 10 Mb/s
   output logic            busy              // Back pressure held
);
   logic [CW-1:0] cnt_q, cnt_d;
   logic [CW-1:0] load;

   // Load value from the duration table plus the 10 Mb/s extension
   always_comb
   begin
      load = CW'(afc_dur_us(dur_sel) * US_CYC);
      if (speed_10m)
         load = load + CW'(EXTRA_10M_CYC);
      cnt_d = cnt_q;
      if (abort)
         cnt_d = '0;
      else if (start)
         cnt_d = load;
      else if (cnt_q != '0)
         cnt_d = cnt_q - CW'(1);
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

   assign busy = (cnt_q != '0);
endmodule

//--- afc_flow_ctrl.sv
// Top of the automatic receive flow controller: thresholds, pause requests and jam control
`timescale 1ns/1ps

module afc_flow_ctrl
   import afc_pkg::*;
#(
   parameter int FILL_W = 14,                // Width of the FIFO fill count in bytes
   parameter int TIME_W = 16,                // Width of the pause time
   parameter int JAM_CW = 18                 // Jam timer width
)
(
   input  wire logic              mclk,           // System clock
   input  wire logic              rst,            // Async reset, active high
   input  wire logic              psel,           // APB select
   input  wire logic              penable,        // APB enable
   input  wire logic              pwrite,         // APB direction
   input  wire logic [7:0]        paddr,          // APB byte address
   input  wire logic [31:0]       pwdata,         // APB write data
   output logic      [31:0]       prdata,         // APB read data
   output logic                   pready,         // APB ready
   output logic                   pslverr,        // APB error
   input  wire logic [FILL_W-1:0] rx_fill_bytes,  // RX data FIFO fill in bytes
   input  wire logic              tx_enabled,     // Transmitter enabled
   input  wire logic              full_duplex,    // Link in full duplex
   input  wire logic              speed_10m,      // Link at 10 Mb/s
   input  wire logic [TIME_W-1:0] pause_time_value, // Programmed pause time
   input  wire logic              rx_preamble,    // Valid preamble seen, pulse
   input  wire logic              rx_addr_valid,  // Destination decoded, pulse
   input  wire logic              rx_is_mcast,    // Frame is multicast
   input  wire logic              rx_is_bcast,    // Frame is broadcast
   input  wire logic              rx_is_own,      // Frame is for our address
   output logic                   pause_req,      // Pause frame request, level
   output logic      [TIME_W-1:0] pause_time,     // Pause time of request
   input  wire logic              pause_ack,      // MAC took the request, pulse
   output logic                   back_pressure   // Jam the line
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [23:0] cfg;          // Configuration fields
   logic        sw_pause;     // Software pause pulse
   logic        sw_jam;       // Software jam pulse
   logic [31:0] status_word;  // Readable status
   logic [7:0]  hi_lvl;       // High level in units
   logic [7:0]  lo_lvl;       // Low level in units
   logic [3:0]  dur_sel;      // Jam duration code
   logic        trig_any;     // Any frame triggers
   logic        trig_mult;    // Multicast triggers
   logic        trig_brd;     // Broadcast triggers
   logic        trig_add;     // Own address triggers
   logic        auto_on;      // Some trigger bit set

   assign hi_lvl    = cfg[HI_MSB:HI_LSB];
   assign lo_lvl    = cfg[LO_MSB:LO_LSB];
   assign dur_sel   = cfg[DUR_MSB:DUR_LSB];
   assign trig_mult = cfg[MULT_BIT];
   assign trig_brd  = cfg[BRD_BIT];
   assign trig_add  = cfg[ADD_BIT];
   assign trig_any  = cfg[ANY_BIT];
   assign auto_on   = |cfg[3:0];

   afc_apb_regs u_regs
   (
      .mclk        (mclk),
      .rst         (rst),
      .psel        (psel),
      .penable     (penable),
      .pwrite      (pwrite),
      .paddr       (paddr),
      .pwdata      (pwdata),
      .prdata      (prdata),
      .pready      (pready),
      .pslverr     (pslverr),
      .status_word (status_word),
      .cfg         (cfg),
      .sw_pause    (sw_pause),
      .sw_jam      (sw_jam)
   );

   // ----------------------------------------------------------------
   // Fill level in 64-byte units
   // ----------------------------------------------------------------
   logic [FILL_W-1:0] fill_units;
   logic              at_high, below_low;

   // Level to fill width; FILL_W must be at least 8
   function automatic logic [FILL_W-1:0] lvl_units(input logic [7:0] lvl);
      return FILL_W'(lvl);
   endfunction

   assign fill_units = rx_fill_bytes >> UNIT_SHIFT;
   // Threshold of zero counts as reached only once enabled; 8 bits cover 16 KB
   assign at_high   = auto_on && (fill_units >= lvl_units(hi_lvl));
   assign below_low = fill_units < lvl_units(lo_lvl);

   // ----------------------------------------------------------------
   // Full duplex pause sequencing
   // ----------------------------------------------------------------
   afc_state_t        st_q, st_d;
   logic              sent_q, sent_d;
   logic              req_q, req_d;
   logic [TIME_W-1:0] ptime_q, ptime_d;
   logic              fd_frame_trig;
   logic              fd_match;

   // Any-frame mode waits for the next preamble; otherwise no frame needed
   always_comb
   begin
      fd_match = 1'b1;
      if (trig_any)
         fd_match = rx_preamble;
   end

   always_comb
   begin
      st_d          = st_q;
      sent_d        = sent_q;
      req_d         = req_q;
      ptime_d       = ptime_q;
      fd_frame_trig = 1'b0;
      if (req_q && pause_ack)
         req_d = 1'b0;
      if (!tx_enabled)
      begin
         req_d = 1'b0;
         st_d  = AFC_IDLE;
      end
      else
      begin
         case (st_q)
            AFC_IDLE:
            begin
               if (full_duplex && at_high && fd_match && !req_q)
               begin
                  req_d         = 1'b1;
                  ptime_d       = pause_time_value;
                  fd_frame_trig = 1'b1;
                  st_d          = AFC_HIGH;
               end
               else if (sw_pause && !req_q)
               begin
                  req_d   = 1'b1;
                  ptime_d = pause_time_value;
               end
            end
            AFC_HIGH:
            begin
               // One frame per high crossing; wait until it is taken
               if (!req_q)
               begin
                  sent_d = 1'b1;
                  st_d   = AFC_WAIT;
               end
            end
            AFC_WAIT:
            begin
               if (below_low && sent_q && auto_on)
               begin
                  req_d   = 1'b1;
                  ptime_d = '0;
                  sent_d  = 1'b0;
                  st_d    = AFC_IDLE;
               end
               else if (!auto_on)
               begin
                  sent_d = 1'b0;
                  st_d   = AFC_IDLE;
               end
            end
            default: st_d = AFC_IDLE;
         endcase
      end
   end

   // Pause state registers
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         st_q    <= AFC_IDLE;
         sent_q  <= 1'b0;
         req_q   <= 1'b0;
         ptime_q <= '0;
      end
      else
      begin
         st_q    <= st_d;
         sent_q  <= sent_d;
         req_q   <= req_d;
         ptime_q <= ptime_d;
      end
   end

   // ----------------------------------------------------------------
   // Half duplex jam decision
   // ----------------------------------------------------------------
   logic hd_match, jam_start, jam_busy;

   // Any-frame acts at preamble and overrides the address filters
   always_comb
   begin
      hd_match = 1'b0;
      if (trig_any)
         hd_match = rx_preamble;
      else if (rx_addr_valid)
         hd_match = (trig_mult && rx_is_mcast)
                 || (trig_brd && rx_is_bcast)
                 || (trig_add && rx_is_own);
   end

   // Duration only matters here, so full duplex never starts the timer
   assign jam_start = tx_enabled && !full_duplex && !jam_busy
                      && ((at_high && hd_match) || sw_jam);

   afc_jam_timer #(.CW(JAM_CW)) u_jam
   (
      .mclk      (mclk),
      .rst       (rst),
      .start     (jam_start),
      .abort     (!tx_enabled || full_duplex),
      .dur_sel   (dur_sel),
      .speed_10m (speed_10m),
      .busy      (jam_busy)
   );

   // ----------------------------------------------------------------
   // Outputs and status
   // ----------------------------------------------------------------
   assign pause_req     = req_q && tx_enabled;
   assign pause_time    = ptime_q;
   assign back_pressure = jam_busy && tx_enabled;
   assign status_word   = {26'h0000000, st_q, at_high, below_low, sent_q, jam_busy};

endmodule

//--- afc_flow_checker.sv
// Port assertions for the automatic receive flow controller
`timescale 1ns/1ps
module afc_flow_checker
   import afc_pkg::*;
#(
   parameter int TIME_W = 16                // Pause time width
)
(
   input wire logic              mclk,          // Clock
   input wire logic              rst,           // Reset
   input wire logic              psel,          // APB select
   input wire logic              penable,       // APB enable
   input wire logic              pwrite,        // APB direction
   input wire logic [7:0]        paddr,         // APB address
   input wire logic [31:0]       prdata,        // APB read data
   input wire logic              tx_enabled,    // Transmitter on
   input wire logic              full_duplex,   // Duplex mode
   input wire logic              rx_preamble,   // Preamble pulse
   input wire logic              rx_addr_valid, // Address pulse
   input wire logic              pause_req,     // Pause request
   input wire logic [TIME_W-1:0] pause_time,    // Pause time
   input wire logic              pause_ack,     // MAC took it
   input wire logic              back_pressure  // Jam
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // -----------------------------------------------------------
   // Pause handshake, jam and config read checks
   // -----------------------------------------------------------
   sequence s_acked;
      pause_req && pause_ack;
   endsequence
   sequence s_waiting;
      pause_req && !pause_ack && tx_enabled;
   endsequence
   a_pause_txoff: assert property (!tx_enabled |-> !pause_req)
      else $error("pause request with transmitter off");
   a_jam_txoff: assert property (!tx_enabled |-> !back_pressure)
      else $error("back pressure with transmitter off");
   a_pause_stale: assert property (!tx_enabled ##1 tx_enabled |-> !pause_req)
      else $error("stale pause request after transmitter on");
   a_jam_stale: assert property (!tx_enabled ##1 tx_enabled |-> !back_pressure)
      else $error("stale back pressure after transmitter on");
   a_jam_fdx: assert property (full_duplex [*3] |-> !back_pressure)
      else $error("back pressure in full duplex");
   a_pause_holds: assert property (s_waiting |=> pause_req || !tx_enabled)
      else $error("pause request dropped before ack");
   a_pause_drop: assert property (s_acked |=> !pause_req)
      else $error("pause request stands after ack");
   a_time_stable: assert property (s_waiting |=> !pause_req || $stable(pause_time))
      else $error("pause time changed while pending");
   a_cfg_reserved: assert property (psel && penable && !pwrite && paddr == FLOW_CFG_OFFSET |-> prdata[31:24] == 8'h00)
      else $error("reserved config bits read nonzero");
   a_jam_cause: assert property ($rose(back_pressure)
      |-> $past(rx_preamble || rx_addr_valid) || $past(psel && penable && pwrite, 2))
      else $error("back pressure without a frame event");
endmodule

bind afc_flow_ctrl afc_flow_checker #(.TIME_W(TIME_W)) afc_flow_checker_i (.mclk(mclk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .tx_enabled(tx_enabled),
   .full_duplex(full_duplex), .rx_preamble(rx_preamble), .rx_addr_valid(rx_addr_valid), .pause_req(pause_req),
   .pause_time(pause_time), .pause_ack(pause_ack), .back_pressure(back_pressure));

//--- afc_mac_model.sv
// MAC side model that takes pause requests and records the frames it sent
`timescale 1ns/1ps
module afc_mac_model
#(
   parameter int DLY = 3                    // Cycles before a request is taken
)
(
   input wire logic        mclk,       // Clock
   input wire logic        rst,        // Reset
   input wire logic        pause_req,  // Pause request
   input wire logic [15:0] pause_time, // Pause time
   output logic            pause_ack,  // One-cycle ack
   output int              n_frames,   // Frames sent
   output logic [15:0]     last_time   // Time in last frame
);
   int wait_q;
   // Ack after a delay, as a busy transmitter would; one pulse per frame
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         pause_ack <= 1'b0;
         wait_q <= 0;
         n_frames <= 0;
         last_time <= 16'h0000;
      end
      else
      begin
         pause_ack <= 1'b0;
         if (pause_req && !pause_ack && wait_q >= DLY)
         begin
            pause_ack <= 1'b1;
            n_frames <= n_frames + 1;
            last_time <= pause_time;
            wait_q <= 0;
         end
         else if (pause_req && !pause_ack)
            wait_q <= wait_q + 1;
      end
   end
endmodule

//--- tb_top.sv
// Self-checking bench for the automatic receive flow controller
`timescale 1ns/1ps
module tb_top;
   import afc_pkg::*;
   logic        mclk, rst, psel, penable, pwrite, pready, pslverr, err_q;
   logic        tx_enabled, full_duplex, speed_10m, rx_preamble, rx_addr_valid;
   logic        rx_is_mcast, rx_is_bcast, rx_is_own, pause_req, pause_ack, back_pressure;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd_q;
   logic [13:0] rx_fill_bytes;
   logic [15:0] pause_time_value, pause_time, last_time;
   int          errors, n_tests, n_frames, n, us;
   logic [3:0]  codes [4] = '{4'h0, 4'h1, 4'h4, 4'h3};
   logic [3:0]  nibs [4]  = '{4'h4, 4'h8, 4'h2, 4'h3};
   logic        spds [4]  = '{1'b0, 1'b1, 1'b0, 1'b0};

   afc_flow_ctrl afc_flow_ctrl_i (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_fill_bytes(rx_fill_bytes), .tx_enabled(tx_enabled), .full_duplex(full_duplex), .speed_10m(speed_10m),
      .pause_time_value(pause_time_value), .rx_preamble(rx_preamble), .rx_addr_valid(rx_addr_valid),
      .rx_is_mcast(rx_is_mcast), .rx_is_bcast(rx_is_bcast), .rx_is_own(rx_is_own), .pause_req(pause_req),
      .pause_time(pause_time), .pause_ack(pause_ack), .back_pressure(back_pressure));
   afc_mac_model afc_mac_model_i (.mclk(mclk), .rst(rst), .pause_req(pause_req), .pause_time(pause_time),
      .pause_ack(pause_ack), .n_frames(n_frames), .last_time(last_time));

   // -----------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pulse(input logic pre, input logic av, input logic m, input logic b, input logic o);
      @(posedge mclk);
      rx_preamble <= pre;
      rx_addr_valid <= av;
      rx_is_mcast <= m;
      rx_is_bcast <= b;
      rx_is_own <= o;
      @(posedge mclk);
      rx_preamble <= 1'b0;
      rx_addr_valid <= 1'b0;
   endtask
   // Counts jam cycles; bounded so a stuck jam cannot hang the run
   task automatic jam_len(output int cnt);
      cnt = 0;
      for (int i = 0; i < 20000; i++)
      begin
         @(posedge mclk);
         if (back_pressure === 1'b1) cnt++;
         else if (cnt > 0) break;
      end
   endtask
   task automatic settle(input logic [13:0] fill);
      rx_fill_bytes <= fill;
      repeat (30) @(posedge mclk);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Clock and watchdog; the watchdog span is twice the longest expected run
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial
   begin
      repeat (60000) @(posedge mclk);
      errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      test_done;
   end

   // -----------------------------------------------------------
   // Test sequence
   // -----------------------------------------------------------
   initial
   begin
      {rst, tx_enabled, full_duplex} = 3'b100;
      {psel, penable, pwrite, speed_10m, rx_preamble, rx_addr_valid, rx_is_mcast, rx_is_bcast, rx_is_own} = '0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      rx_fill_bytes = 14'h0000;
      pause_time_value = 16'h1234;
      errors = 0;
      n_tests = 0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      apb(1'b0, FLOW_CFG_OFFSET, 32'h0);
      check(rd_q, 32'h0000_0000, "config reset");
      apb(1'b1, FLOW_CFG_OFFSET, 32'hffff_ffff);
      apb(1'b0, FLOW_CFG_OFFSET, 32'h0);
      check(rd_q, 32'h00ff_ffff, "reserved bits");
      apb(1'b0, 8'hf0, 32'h0);
      check(err_q, 1'b1, "unmapped error");
      $display("register test done");
      // Full duplex: one pause at high, one zero pause below low
      full_duplex <= 1'b1;
      tx_enabled <= 1'b1;
      apb(1'b1, FLOW_CFG_OFFSET, 32'h0002_0108);
      settle(14'd128);
      check(n_frames, 1, "pause at high");
      check(last_time, 16'h1234, "pause time");
      settle(14'd64);
      check(n_frames, 1, "no pause at low level");
      settle(14'd63);
      check(n_frames, 2, "zero pause below low");
      check(last_time, 16'h0000, "zero pause time");
      settle(14'd63);
      check(n_frames, 2, "single zero pause");
      $display("pause test done");
      // Transmitter off: nothing sent, so no zero pause follows
      tx_enabled <= 1'b0;
      settle(14'd128);
      apb(1'b1, AFC_CTRL_OFFSET, 32'h0000_0003);
      settle(14'd128);
      check(n_frames, 2, "no pause with tx off");
      settle(14'd0);
      tx_enabled <= 1'b1;
      settle(14'd0);
      check(n_frames, 2, "no unpaired zero pause");
      $display("tx off test done");
      // Jam: none in full duplex, none on an unselected type, then timed jams
      apb(1'b1, FLOW_CFG_OFFSET, 32'h0002_0104);
      settle(14'd128);
      pulse(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
      repeat (3) @(posedge mclk);
      check(back_pressure, 1'b0, "no jam in full duplex");
      full_duplex <= 1'b0;
      pulse(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      repeat (3) @(posedge mclk);
      check(back_pressure, 1'b0, "multicast not selected");
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, FLOW_CFG_OFFSET, {16'h0002, 8'h01, codes[i], nibs[i]});
         speed_10m <= spds[i];
         pulse(nibs[i][0], !nibs[i][0], nibs[i][3], nibs[i][2], nibs[i][1]);
         jam_len(n);
         us = (codes[i] < 4) ? ((codes[i] == 3) ? 25 : 5 * (codes[i] + 1)) : 50 * (codes[i] - 3);
         check(n, 250 * us + (spds[i] ? 550 : 0), "jam length");
      end
      $display("jam test done");
      // Software requests: pause from idle and a jam of the last duration code
      settle(14'd0);
      check(n_frames, 4, "zero pause after jams");
      apb(1'b1, AFC_CTRL_OFFSET, 32'h0000_0003);
      jam_len(n);
      check(n, 6250, "software jam length");
      check(n_frames, 5, "software pause");
      check(last_time, 16'h1234, "software pause time");
      $display("software test done");
      test_done;
   end
endmodule
